// [hw/frp_pkg.sv]
// Package with constants, register map and types of the packet repeater.
package frp_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int ID_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_AW = 5;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFF_CTRL = 5'h00;
  localparam logic [REG_AW-1:0] OFF_SLOTS = 5'h04;
  localparam logic [REG_AW-1:0] OFF_OWN = 5'h08;
  localparam logic [REG_AW-1:0] OFF_STAT = 5'h0C;
  localparam logic [REG_AW-1:0] OFF_MASK = 5'h10;
  localparam logic [REG_AW-1:0] OFF_IND = 5'h14;
  localparam logic [REG_AW-1:0] OFF_TXCMD = 5'h18;
  localparam logic [REG_AW-1:0] OFF_STATE = 5'h1C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_REP = 0;
  localparam int CTRL_SNIFF = 1;
  localparam int CTRL_AMODE = 2;
  localparam int TXCMD_ID = 8;
  localparam int TXCMD_ACK = 16;
  localparam int IND_DST = 8;
  localparam int STATE_HOSTP = 4;
  localparam int STATE_REP = 5;
  localparam int STATE_SNIFF = 6;

  // Sticky status bits, same layout in the mask register.
  localparam int NSTAT = 4;
  localparam int ST_FWD = 0;
  localparam int ST_DLV = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_DROP = 3;

  // ------------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SLOTS_RST = 8'h08;
  localparam logic [ADDR_W-1:0] OWN_RST = 8'h01;
  localparam logic [ADDR_W-1:0] BCAST = 8'hFF;
  localparam logic [1:0] AMODE_DST_ONLY = 2'h0;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // ------------------------------------------------------------------
  // Timing: one delay slot, rounded up to whole clock cycles
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLOT_TIME_NS = 1000;
  localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int CYC_W = $clog2(SLOT_CYCLES);

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    FRP_IDLE,
    FRP_DELAY,
    FRP_CCA,
    FRP_SEND,
    FRP_WAIT
  } frp_state_t;

endpackage

// [hw/frp_repeater.sv]
// Flooding packet repeater with register port and interrupt.
`timescale 1ns/1ns

module frp_repeater #(
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [frp_pkg::REG_AW-1:0] i_addr,
  input wire logic [frp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [frp_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq,
  input wire logic i_rx_valid,
  input wire logic [frp_pkg::ADDR_W-1:0] i_rx_src,
  input wire logic [frp_pkg::ADDR_W-1:0] i_rx_dst,
  input wire logic [frp_pkg::ID_W-1:0] i_rx_id,
  input wire logic i_rx_ack_req,
  input wire logic i_chan_busy,
  input wire logic i_tx_done,
  output logic o_rx_enable,
  output logic o_sniff_en,
  output logic o_tx_start,
  output logic [frp_pkg::ADDR_W-1:0] o_tx_src,
  output logic [frp_pkg::ADDR_W-1:0] o_tx_dst,
  output logic [frp_pkg::ID_W-1:0] o_tx_id,
  output logic o_tx_ack_req,
  output logic o_ack_start,
  output logic [frp_pkg::ADDR_W-1:0] o_ack_dst,
  output logic o_dlv_valid,
  output logic [frp_pkg::ADDR_W-1:0] o_dlv_src,
  output logic [frp_pkg::ID_W-1:0] o_dlv_id,
  output logic o_ind_valid,
  output logic [frp_pkg::ADDR_W-1:0] o_ind_src,
  output logic [frp_pkg::ADDR_W-1:0] o_ind_dst
);

  localparam int AW = frp_pkg::ADDR_W;
  localparam int IW = frp_pkg::ID_W;
  localparam int ENT_W = AW + IW;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [frp_pkg::CYC_W-1:0] CYC_LAST =
    frp_pkg::CYC_W'(frp_pkg::SLOT_CYCLES - 1);

  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed {
    frp_pkg::frp_state_t st;
    logic rep_en, sniff_en;
    logic [1:0] amode;
    logic [AW-1:0] slots, own;
    logic [frp_pkg::NSTAT-1:0] stat, mask;
    logic [AW-1:0] ind_src, ind_dst;
    logic [AW-1:0] p_src, p_dst;
    logic [IW-1:0] p_id;
    logic p_ack, p_fwd;
    logic host_pend;
    logic [AW-1:0] h_dst;
    logic [IW-1:0] h_id;
    logic h_ack;
    logic [AW-1:0] slot_cnt;
    logic [frp_pkg::CYC_W-1:0] cyc_cnt;
    logic [15:0] lfsr;
    logic [DEPTH-1:0][ENT_W-1:0] tbl;
    logic [DEPTH-1:0] tvld;
    logic [PTR_W-1:0] wptr;
    logic [frp_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic tx_start, ack_start;
    logic [AW-1:0] ack_dst;
    logic dlv_valid;
    logic [AW-1:0] dlv_src;
    logic [IW-1:0] dlv_id;
    logic ind_valid;
  } frp_regs_t;

  frp_regs_t s_reg;
  frp_regs_t s_next;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Draws a slot below the slot count; a count of zero acts as one slot.
  function automatic logic [AW-1:0] pick_slot(input logic [15:0] rnd,
                                               input logic [AW-1:0] n);
    logic [AW-1:0] d;
    d = (n == '0) ? AW'(1) : n;
    return rnd[AW-1:0] % d;
  endfunction

  // True when the sender and identifier pair sits in the history table.
  function automatic logic seen(input logic [DEPTH-1:0][ENT_W-1:0] t,
                                input logic [DEPTH-1:0] v,
                                input logic [ENT_W-1:0] key);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (v[i] && t[i] == key) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // One process computes register port, reception path and sequencer.
  always_comb begin
    logic [frp_pkg::NSTAT-1:0] set_v;
    logic [frp_pkg::NSTAT-1:0] clr_v;
    logic [ENT_W-1:0] key;
    logic to_me;
    logic want_fwd;
    set_v = '0;
    clr_v = '0;
    key = {i_rx_src, i_rx_id};
    to_me = (i_rx_dst == s_reg.own) || (i_rx_dst == frp_pkg::BCAST);
    want_fwd = s_reg.rep_en && (i_rx_dst != s_reg.own) &&
               (i_rx_src != s_reg.own);
    s_next = s_reg;
    s_next.tx_start = 1'b0;
    s_next.ack_start = 1'b0;
    s_next.dlv_valid = 1'b0;
    s_next.ind_valid = 1'b0;
    s_next.rdata = '0;
    s_next.lfsr = {s_reg.lfsr[14:0],
                   s_reg.lfsr[15] ^ s_reg.lfsr[13] ^
                   s_reg.lfsr[12] ^ s_reg.lfsr[10]};

    // Register writes; the clear of a sticky bit loses to a new event.
    if (i_wr) begin
      case (i_addr)
        frp_pkg::OFF_CTRL: begin
          s_next.rep_en = i_wdata[frp_pkg::CTRL_REP];
          s_next.amode = i_wdata[frp_pkg::CTRL_AMODE +: 2];
          // A sniffer request beside repeating is refused and flagged.
          s_next.sniff_en = i_wdata[frp_pkg::CTRL_SNIFF] &
                            ~i_wdata[frp_pkg::CTRL_REP];
          set_v[frp_pkg::ST_CONFLICT] = i_wdata[frp_pkg::CTRL_SNIFF] &
                                        i_wdata[frp_pkg::CTRL_REP];
        end
        frp_pkg::OFF_SLOTS: s_next.slots = i_wdata[AW-1:0];
        frp_pkg::OFF_OWN: s_next.own = i_wdata[AW-1:0];
        frp_pkg::OFF_STAT: clr_v = i_wdata[frp_pkg::NSTAT-1:0];
        frp_pkg::OFF_MASK: s_next.mask = i_wdata[frp_pkg::NSTAT-1:0];
        frp_pkg::OFF_TXCMD: begin
          // Host send request; a second one while pending is ignored.
          if (!s_reg.host_pend) begin
            s_next.host_pend = 1'b1;
            s_next.h_dst = i_wdata[AW-1:0];
            s_next.h_id = i_wdata[frp_pkg::TXCMD_ID +: IW];
            s_next.h_ack = i_wdata[frp_pkg::TXCMD_ACK];
          end
        end
        default: ;
      endcase
    end

    // Register reads; data stand in the following cycle only.
    if (i_rd) begin
      case (i_addr)
        frp_pkg::OFF_CTRL: begin
          s_next.rdata[frp_pkg::CTRL_REP] = s_reg.rep_en;
          s_next.rdata[frp_pkg::CTRL_SNIFF] = s_reg.sniff_en;
          s_next.rdata[frp_pkg::CTRL_AMODE +: 2] = s_reg.amode;
        end
        frp_pkg::OFF_SLOTS: s_next.rdata[AW-1:0] = s_reg.slots;
        frp_pkg::OFF_OWN: s_next.rdata[AW-1:0] = s_reg.own;
        frp_pkg::OFF_STAT: s_next.rdata[frp_pkg::NSTAT-1:0] = s_reg.stat;
        frp_pkg::OFF_MASK: s_next.rdata[frp_pkg::NSTAT-1:0] = s_reg.mask;
        frp_pkg::OFF_IND: begin
          s_next.rdata[AW-1:0] = s_reg.ind_src;
          s_next.rdata[frp_pkg::IND_DST +: AW] = s_reg.ind_dst;
        end
        frp_pkg::OFF_STATE: begin
          s_next.rdata[2:0] = s_reg.st;
          s_next.rdata[frp_pkg::STATE_HOSTP] = s_reg.host_pend;
          s_next.rdata[frp_pkg::STATE_REP] = s_reg.rep_en;
          s_next.rdata[frp_pkg::STATE_SNIFF] = s_reg.sniff_en;
        end
        default: s_next.rdata = '0;
      endcase
    end

    // Reception: deliver own and broadcast packets, acknowledge if allowed.
    if (i_rx_valid) begin
      if (to_me || s_reg.sniff_en) begin
        s_next.dlv_valid = 1'b1;
        s_next.dlv_src = i_rx_src;
        s_next.dlv_id = i_rx_id;
        set_v[frp_pkg::ST_DLV] = 1'b1;
      end
      // Acknowledge requests are ignored entirely while repeating.
      if (!s_reg.rep_en && i_rx_dst == s_reg.own && i_rx_ack_req) begin
        s_next.ack_start = 1'b1;
        s_next.ack_dst = i_rx_src;
      end
      if (want_fwd) begin
        if (seen(s_reg.tbl, s_reg.tvld, key)) begin
          set_v[frp_pkg::ST_DROP] = 1'b1;
        end else if (s_reg.st != frp_pkg::FRP_IDLE) begin
          // Only one forward is held; a busy repeater loses the packet.
          set_v[frp_pkg::ST_DROP] = 1'b1;
        end else begin
          // Entered at capture so copies arriving during the wait drop.
          s_next.tbl[s_reg.wptr] = key;
          s_next.tvld[s_reg.wptr] = 1'b1;
          s_next.wptr = (s_reg.wptr == PTR_LAST) ? '0 :
                        s_reg.wptr + 1'b1;
          s_next.p_src = i_rx_src;
          s_next.p_dst = i_rx_dst;
          s_next.p_id = i_rx_id;
          s_next.p_ack = 1'b0;
          s_next.p_fwd = 1'b1;
          s_next.slot_cnt = pick_slot(s_reg.lfsr, s_reg.slots);
          s_next.cyc_cnt = CYC_LAST;
          s_next.st = frp_pkg::FRP_DELAY;
        end
      end
    end

    // Sequencer: random wait, channel check, send, completion.
    case (s_reg.st)
      frp_pkg::FRP_IDLE: begin
        if (s_next.st == frp_pkg::FRP_IDLE && s_reg.host_pend) begin
          s_next.host_pend = 1'b0;
          s_next.p_src = s_reg.own;
          s_next.p_dst = s_reg.h_dst;
          s_next.p_id = s_reg.h_id;
          s_next.p_ack = s_reg.h_ack;
          s_next.p_fwd = 1'b0;
          s_next.st = frp_pkg::FRP_CCA;
        end
      end
      frp_pkg::FRP_DELAY: begin
        if (s_reg.cyc_cnt != '0) begin
          s_next.cyc_cnt = s_reg.cyc_cnt - 1'b1;
        end else if (s_reg.slot_cnt != '0) begin
          s_next.slot_cnt = s_reg.slot_cnt - 1'b1;
          s_next.cyc_cnt = CYC_LAST;
        end else begin
          s_next.st = frp_pkg::FRP_CCA;
        end
      end
      frp_pkg::FRP_CCA: begin
        // A busy channel draws a fresh delay rather than waiting in line.
        if (i_chan_busy) begin
          s_next.slot_cnt = pick_slot(s_reg.lfsr, s_reg.slots);
          s_next.cyc_cnt = CYC_LAST;
          s_next.st = frp_pkg::FRP_DELAY;
        end else begin
          s_next.st = frp_pkg::FRP_SEND;
        end
      end
      frp_pkg::FRP_SEND: begin
        s_next.tx_start = 1'b1;
        s_next.st = frp_pkg::FRP_WAIT;
      end
      frp_pkg::FRP_WAIT: begin
        if (i_tx_done) begin
          s_next.st = frp_pkg::FRP_IDLE;
          if (s_reg.p_fwd) begin
            s_next.ind_valid = 1'b1;
            set_v[frp_pkg::ST_FWD] = 1'b1;
            s_next.ind_dst = s_reg.p_dst;
            s_next.ind_src = (s_reg.amode == frp_pkg::AMODE_DST_ONLY) ?
                             '0 : s_reg.p_src;
          end
        end
      end
      default: s_next.st = frp_pkg::FRP_IDLE;
    endcase

    s_next.stat = (s_reg.stat & ~clr_v) | set_v;
    s_next.irq = |(s_next.stat & s_next.mask);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Asynchronous reset to constants; everything else on the clock.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
      s_reg.st <= frp_pkg::FRP_IDLE;
      s_reg.slots <= frp_pkg::SLOTS_RST;
      s_reg.own <= frp_pkg::OWN_RST;
      s_reg.lfsr <= frp_pkg::LFSR_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all but the constant receiver enable straight from the state record
  // ------------------------------------------------------------------
  assign o_rdata = s_reg.rdata;
  assign o_irq = s_reg.irq;
  // The receiver is never switched off, so repeating always listens.
  assign o_rx_enable = 1'b1;
  assign o_sniff_en = s_reg.sniff_en;
  assign o_tx_start = s_reg.tx_start;
  assign o_tx_src = s_reg.p_src;
  assign o_tx_dst = s_reg.p_dst;
  assign o_tx_id = s_reg.p_id;
  assign o_tx_ack_req = s_reg.p_ack;
  assign o_ack_start = s_reg.ack_start;
  assign o_ack_dst = s_reg.ack_dst;
  assign o_dlv_valid = s_reg.dlv_valid;
  assign o_dlv_src = s_reg.dlv_src;
  assign o_dlv_id = s_reg.dlv_id;
  assign o_ind_valid = s_reg.ind_valid;
  assign o_ind_src = s_reg.ind_src;
  assign o_ind_dst = s_reg.ind_dst;

endmodule

// [tb/frp_repeater_asserts.sv]
// Port checker of the flooding packet repeater.
`timescale 1ns/1ns
module frp_repeater_asserts #(
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [frp_pkg::REG_AW-1:0] i_addr,
  input wire logic [frp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rx_valid,
  input wire logic [frp_pkg::ADDR_W-1:0] i_rx_src,
  input wire logic [frp_pkg::ADDR_W-1:0] i_rx_dst,
  input wire logic i_rx_ack_req,
  input wire logic i_chan_busy,
  input wire logic i_tx_done,
  input wire logic o_rx_enable,
  input wire logic o_sniff_en,
  input wire logic o_tx_start,
  input wire logic [frp_pkg::ADDR_W-1:0] o_tx_dst,
  input wire logic o_tx_ack_req,
  input wire logic o_ack_start,
  input wire logic [frp_pkg::ADDR_W-1:0] o_ack_dst,
  input wire logic o_dlv_valid,
  input wire logic [frp_pkg::ADDR_W-1:0] o_dlv_src,
  input wire logic o_ind_valid,
  input wire logic [frp_pkg::ADDR_W-1:0] o_ind_dst
);
  logic rep_reg;
  logic [frp_pkg::ADDR_W-1:0] own_reg;

  // Shadows of the repeat bit and own address, so no internal probes.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rep_reg <= 1'b0;
      own_reg <= frp_pkg::OWN_RST;
    end else if (i_wr && i_addr == frp_pkg::OFF_CTRL) begin
      rep_reg <= i_wdata[frp_pkg::CTRL_REP];
    end else if (i_wr && i_addr == frp_pkg::OFF_OWN) begin
      own_reg <= i_wdata[frp_pkg::ADDR_W-1:0];
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // A header that names this node as its destination.
  sequence own_rx;
    i_rx_valid && i_rx_dst == own_reg;
  endsequence

  // Long enough that any clear-channel check inside it saw the channel busy.
  sequence chan_held;
    i_chan_busy [*6];
  endsequence

  AST_RX_ON: assert property (o_rx_enable)
    else $error("receiver switched off");
  AST_SNIFF_EXCL: assert property (
    i_wr && i_addr == frp_pkg::OFF_CTRL && i_wdata[1:0] == 2'h3
    |=> !o_sniff_en)
    else $error("sniffer on beside repeating");
  AST_ACK_BLOCK: assert property (
    i_rx_valid && rep_reg |=> !o_ack_start)
    else $error("acknowledge sent while repeating");
  AST_ACK_GIVEN: assert property (
    own_rx ##0 (!rep_reg && i_rx_ack_req)
    |=> o_ack_start && o_ack_dst == $past(i_rx_src))
    else $error("normal node did not acknowledge");
  AST_DLV: assert property (own_rx
    |=> o_dlv_valid && o_dlv_src == $past(i_rx_src))
    else $error("own packet not delivered");
  AST_CCA: assert property (chan_held |-> !o_tx_start)
    else $error("send started on a busy channel");
  AST_IND_DONE: assert property (o_ind_valid |-> $past(i_tx_done))
    else $error("indication without finished send");
  AST_IND_NOACK: assert property (o_ind_valid
    |-> !o_tx_ack_req && o_ind_dst == o_tx_dst)
    else $error("forward asked for acknowledge or wrong indication");
endmodule

// [tb/frp_radio_model.sv]
// Behavioural model of the neighbouring nodes on the shared channel.
`timescale 1ns/1ns
module frp_radio_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_tx_start,
  input wire logic i_busy_req,
  input wire logic [7:0] i_lat,
  output logic o_chan_busy,
  output logic o_tx_done
);
  logic [7:0] air_reg;

  // A frame stays on air for i_lat + 1 cycles, then done pulses once.
  // Neighbours share profile, channel and address mode.
  // They never retry, but their headers may ask for an acknowledgement.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      air_reg <= 8'h00;
      o_tx_done <= 1'b0;
    end else begin
      o_tx_done <= (air_reg == 8'h01);
      if (i_tx_start) begin
        air_reg <= i_lat + 8'h01;
      end else if (air_reg != 8'h00) begin
        air_reg <= air_reg - 8'h01;
      end
    end
  end

  // Busy while a frame is on air or another node holds the channel.
  assign o_chan_busy = i_busy_req || air_reg != 8'h00;
endmodule

// [tb/flooding_packet_repeater_bench.sv]
// Self-checking bench of the flooding packet repeater.
`timescale 1ns/1ns
module flooding_packet_repeater_bench;
  localparam int DEPTH = 4;
  localparam logic [4:0] OFFS [5] = '{frp_pkg::OFF_CTRL, frp_pkg::OFF_SLOTS,
    frp_pkg::OFF_OWN, frp_pkg::OFF_MASK, 5'h1E};
  localparam logic [31:0] RSTV [5] = '{32'h0000_0000,
    32'(frp_pkg::SLOTS_RST), 32'(frp_pkg::OWN_RST), 32'h0000_0000,
    32'h0000_0000};
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_rx_valid = 1'b0, i_rx_ack_req = 1'b0, busy_req = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, v;
  logic [7:0] i_rx_src = 8'h00, i_rx_dst = 8'h00, i_rx_id = 8'h00;
  logic [7:0] lat = 8'h04, o_tx_src, o_tx_dst, o_tx_id, o_ack_dst;
  logic [1:0] am = 2'h1;
  logic [7:0] o_dlv_src, o_dlv_id, o_ind_src, o_ind_dst, s0, d0, id0, s, d, id;
  logic o_irq, i_chan_busy, i_tx_done, o_rx_enable, o_sniff_en;
  logic o_tx_start, o_tx_ack_req, o_ack_start, o_dlv_valid, o_ind_valid;
  int err_count = 0, n_tests = 0, n_tx = 0, n_ind = 0, n_ack = 0, n_dlv = 0;

  frp_repeater #(.DEPTH(DEPTH)) u_dut (.i_ref_clk, .i_resetn, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_rx_valid, .i_rx_src,
    .i_rx_dst, .i_rx_id, .i_rx_ack_req, .i_chan_busy, .i_tx_done, .o_rx_enable,
    .o_sniff_en, .o_tx_start, .o_tx_src, .o_tx_dst, .o_tx_id, .o_tx_ack_req,
    .o_ack_start, .o_ack_dst, .o_dlv_valid, .o_dlv_src, .o_dlv_id,
    .o_ind_valid, .o_ind_src, .o_ind_dst);
  frp_radio_model u_radio (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_tx_start(o_tx_start), .i_busy_req(busy_req), .i_lat(lat),
    .o_chan_busy(i_chan_busy), .o_tx_done(i_tx_done));

  // Free running 125 MHz reference clock.
  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // Counts output pulses; values are sampled before the edge updates land.
  always @(posedge i_ref_clk) begin
    n_tx += o_tx_start;
    n_ind += o_ind_valid;
    n_ack += o_ack_start;
    n_dlv += o_dlv_valid;
  end

  // Indication source is blanked in the destination-only address mode.
  function automatic logic [7:0] ind_src_exp(input logic [1:0] am,
                                             input logic [7:0] a);
    return (am == frp_pkg::AMODE_DST_ONLY) ? 8'h00 : a;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] dat);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dat;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rreg(input logic [4:0] a, output logic [31:0] dat);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    dat = o_rdata;
  endtask

  task automatic rx(input logic [7:0] a, b, c, input logic ak);
    @(posedge i_ref_clk);
    i_rx_valid <= 1'b1;
    i_rx_src <= a;
    i_rx_dst <= b;
    i_rx_id <= c;
    i_rx_ack_req <= ak;
    @(posedge i_ref_clk);
    i_rx_valid <= 1'b0;
    i_rx_dst <= ~b;
  endtask

  // Bounded wait for a pulse counter to reach a value.
  task automatic settle(ref int c, input int want);
    for (int k = 0; k < 600 && c < want; k++) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask

  // Sends one header and compares the forward that it should cause.
  task automatic fwd(input logic [7:0] a, b, c, input logic ak, yes);
    int n;
    n = n_ind;
    rx(a, b, c, ak);
    settle(n_ind, n + 1);
    check(32'(n_ind), 32'(n + yes));
    if (yes) begin
      check({o_tx_src, o_tx_dst, o_tx_id}, {8'h00, a, b, c});
      check(o_tx_ack_req, 1'b0);
      check({o_ind_src, o_ind_dst}, {ind_src_exp(am, a), b});
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    final_report();
  end

  // Main sequence of scenarios.
  initial begin
    v = $urandom(32'hcc75_8013);
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    wreg(5'h1E, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      rreg(OFFS[i], v);
      check(v, RSTV[i]);
    end
    // Repeating off: foreign packet stays, own one is acknowledged.
    fwd(8'h33, 8'h44, 8'h10, 1'b1, 1'b0);
    rx(8'h33, frp_pkg::OWN_RST, 8'h11, 1'b1);
    settle(n_ack, 1);
    check(32'(n_ack), 32'd1);
    wreg(frp_pkg::OFF_SLOTS, 32'h0000_0001);
    wreg(frp_pkg::OFF_MASK, 32'h0000_000F);
    wreg(frp_pkg::OFF_CTRL, 32'h0000_0005);
    rreg(frp_pkg::OFF_STATE, v);
    check(v[6:5], 2'h1);
    // One packet more than the history holds, with random fields.
    // Each packet waits for its forward, so traffic stays light.
    for (int i = 0; i <= DEPTH; i++) begin
      s = 8'h02 + 8'($urandom % 200);
      d = s + 8'h01;
      id = {4'(i), 4'($urandom)};
      lat <= 8'($urandom % 16);
      if (i == 0) {s0, d0, id0} = {s, d, id};
      fwd(s, d, id, 1'($urandom), 1'b1);
      check(o_irq, 1'b1);
      rreg(frp_pkg::OFF_STAT, v);
      check(v[0], 1'b1);
      wreg(frp_pkg::OFF_STAT, 32'h0000_000F);
      rreg(frp_pkg::OFF_STAT, v);
      check({v[3:0], o_irq}, 5'h00);
    end
    // Newest entry is a repeat; the oldest was pushed out of the table.
    fwd(s, d, id, 1'b0, 1'b0);
    rreg(frp_pkg::OFF_STAT, v);
    check(v[3], 1'b1);
    // A far receiver sees this copy twice and must drop it itself.
    fwd(s0, d0, id0, 1'b0, 1'b1);
    // Own packet while repeating: delivered, not acknowledged, not sent.
    fwd(8'h40, frp_pkg::OWN_RST, 8'hE0, 1'b1, 1'b0);
    check(32'(n_dlv), 32'd2);
    check({o_dlv_src, o_dlv_id}, 16'h40E0);
    check(32'(n_ack), 32'd1);
    // A busy channel holds the forward back until it clears.
    busy_req <= 1'b1;
    rx(8'h50, 8'h60, 8'hF0, 1'b0);
    repeat (400) @(posedge i_ref_clk);
    check(32'(n_tx), 32'(DEPTH + 2));
    busy_req <= 1'b0;
    settle(n_tx, DEPTH + 3);
    check(32'(n_tx), 32'(DEPTH + 3));
    repeat (40) @(posedge i_ref_clk);
    // Host send is still taken while repeating.
    wreg(frp_pkg::OFF_TXCMD, 32'h0001_5A77);
    settle(n_tx, DEPTH + 4);
    check({o_tx_dst, o_tx_id}, 16'h775A);
    check({o_tx_ack_req, o_tx_src}, {1'b1, frp_pkg::OWN_RST});
    repeat (40) @(posedge i_ref_clk);
    // Destination-only address mode blanks the indication source.
    am = 2'h0;
    wreg(frp_pkg::OFF_CTRL, 32'h0000_0001);
    fwd(8'h21, 8'h22, 8'h23, 1'b1, 1'b1);
    // Both modes at once: sniffing refused and flagged, masked then not.
    wreg(frp_pkg::OFF_MASK, 32'h0000_0000);
    wreg(frp_pkg::OFF_CTRL, 32'h0000_0003);
    rreg(frp_pkg::OFF_STAT, v);
    check({v[2], o_sniff_en, o_irq}, 3'h4);
    wreg(frp_pkg::OFF_MASK, 32'h0000_0004);
    wreg(frp_pkg::OFF_CTRL, 32'h0000_0002);
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check({o_sniff_en, o_irq}, 2'h3);
    // Reset in mid-run returns control and outputs to idle.
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rreg(frp_pkg::OFF_CTRL, v);
    check({v[29:0], o_sniff_en, o_irq}, 32'h0000_0000);
    final_report();
  end
endmodule

bind frp_repeater frp_repeater_asserts #(.DEPTH(DEPTH)) u_chk (
  .i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rx_valid, .i_rx_src,
  .i_rx_dst, .i_rx_ack_req, .i_chan_busy, .i_tx_done, .o_rx_enable,
  .o_sniff_en, .o_tx_start, .o_tx_dst, .o_tx_ack_req, .o_ack_start,
  .o_ack_dst, .o_dlv_valid, .o_dlv_src, .o_ind_valid, .o_ind_dst);
